// file: src/ubs_pkg.sv
// constants and types shared by the boot selector and its indicator generator
package ubs_pkg;
  // flash map
  localparam logic [23:0] UBS_APP_BASE     = 24'h002000;
  localparam logic [23:0] UBS_FLASH_END    = 24'h008000;
  localparam logic [23:0] UBS_VEC_RESET    = 24'h000000;
  localparam logic [23:0] UBS_VEC_LOADER   = 24'h000004;
  localparam logic [23:0] UBS_VEC_HIGH     = 24'h000008;
  localparam logic [23:0] UBS_VEC_LOW      = 24'h000018;
  localparam logic [23:0] UBS_APP_HIGH     = 24'h002008;
  localparam logic [23:0] UBS_APP_LOW      = 24'h002018;
  localparam logic [23:0] UBS_CFG_BASE     = 24'h300000;
  localparam logic [23:0] UBS_EE_BASE      = 24'hf00000;
  localparam logic [15:0] UBS_BLANK_WORD   = 16'hffff;
  // fixed configuration bytes, never writable
  localparam logic [7:0]  UBS_CFG_1L       = 8'h23;
  localparam logic [7:0]  UBS_CFG_3H       = 8'hd3;
  localparam logic [7:0]  UBS_CFG_4L       = 8'h85;
  // read-only data area
  localparam logic [7:0]  UBS_DESC_FIRST   = 8'h40;
  localparam logic [7:0]  UBS_DESC_LAST    = 8'h51;
  localparam logic [7:0]  UBS_SER_FIRST    = 8'h60;
  localparam logic [7:0]  UBS_SER_LAST     = 8'h70;
  localparam logic [7:0]  UBS_SDESC_FIRST  = 8'h80;
  localparam logic [7:0]  UBS_SDESC_LAST   = 8'ha1;
  localparam logic [7:0]  UBS_STRING_TYPE  = 8'h03;
  localparam int          UBS_SERIAL_LEN   = 8;
  // ram clear
  localparam int          UBS_RAM_AW       = 10;
  localparam logic [9:0]  UBS_RAM_LAST     = 10'h3ff;
  // timing
  localparam int unsigned UBS_CLK_PERIOD_NS = 40;
  localparam int unsigned UBS_MS_NS         = 1000000;
  localparam int unsigned UBS_MS_CYCLES     = UBS_MS_NS / UBS_CLK_PERIOD_NS;
  localparam logic [10:0] UBS_PERIOD_MS     = 11'd1400;
  localparam logic [10:0] UBS_HALF_MS       = 11'd700;
  localparam logic [10:0] UBS_IDLE_MS       = 11'd1000;
  localparam logic [10:0] UBS_BLINK_MS      = 11'd100;
  localparam logic [10:0] UBS_FLASH_MS      = 11'd50;

  typedef enum logic [1:0] {
    UBS_USB_ABSENT,
    UBS_USB_SUSPEND,
    UBS_USB_ATTACHED,
    UBS_USB_CONFIGURED
  } ubs_usb_t;

  typedef enum logic [2:0] {
    UBS_ST_CLEAR,
    UBS_ST_READ,
    UBS_ST_WAIT,
    UBS_ST_PIN,
    UBS_ST_LOADER,
    UBS_ST_APP
  } ubs_state_t;
endpackage

// file: src/ubs_led_if.sv
// signals between the boot selector and its indicator generator
`timescale 1ns/1ps
`default_nettype none
interface ubs_led_if;
  import ubs_pkg::*;
  ubs_usb_t usb_state;
  logic     cmd_seen;
  logic     loader_on;
  logic     green_on;
  logic     yellow_on;
  modport ctl (output usb_state, output cmd_seen, output loader_on,
               input green_on, input yellow_on);
  modport gen (input usb_state, input cmd_seen, input loader_on,
               output green_on, output yellow_on);
endinterface
`default_nettype wire

// file: src/ubs_led_gen.sv
// indicator blink pattern generator for loader mode
`timescale 1ns/1ps
`default_nettype none
module ubs_led_gen
  import ubs_pkg::*;
#(
  parameter int unsigned MS_CYCLES = UBS_MS_CYCLES
)(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  ubs_led_if.gen    lif
);
  typedef struct packed {
    logic [15:0] tick;
    logic [10:0] ms;
    logic [10:0] flash;
    logic        green;
    logic        yellow;
  } ubs_led_state_t;

  ubs_led_state_t s;
  ubs_led_state_t next_s;

  // one free-running count keeps every pattern in phase
  always_comb
  begin
    logic        ms_tick;
    logic        idle;
    logic [10:0] limit;
    ms_tick = 1'b0;
    idle    = 1'b0;
    limit   = UBS_PERIOD_MS;
    next_s  = s;
    ms_tick = (s.tick == 16'(MS_CYCLES - 1));
    next_s.tick = ms_tick ? 16'h0000 : s.tick + 16'h0001;
    idle  = (lif.usb_state == UBS_USB_ABSENT) || (lif.usb_state == UBS_USB_SUSPEND);
    limit = idle ? UBS_IDLE_MS : UBS_PERIOD_MS;
    if (ms_tick)
    begin
      next_s.ms = (s.ms >= limit - 11'd1) ? 11'h000 : s.ms + 11'd1;
      if (s.flash != 11'h000)
        next_s.flash = s.flash - 11'd1;
    end
    if (lif.cmd_seen)
      next_s.flash = UBS_FLASH_MS;
    unique case (lif.usb_state)
      UBS_USB_ABSENT, UBS_USB_SUSPEND:
      begin
        next_s.green  = (s.ms < UBS_BLINK_MS);
        next_s.yellow = 1'b0;
      end
      UBS_USB_ATTACHED:
      begin
        next_s.green  = (s.ms < UBS_HALF_MS);
        next_s.yellow = (s.flash == 11'h000);
      end
      UBS_USB_CONFIGURED:
      begin
        // two short blinks at the start of each period
        next_s.green  = (s.ms < UBS_BLINK_MS)
                     || ((s.ms >= 2 * UBS_BLINK_MS) && (s.ms < 3 * UBS_BLINK_MS));
        next_s.yellow = (s.flash == 11'h000);
      end
    endcase
    if (!lif.loader_on)
    begin
      next_s.green  = 1'b0;
      next_s.yellow = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign lif.green_on  = s.green;
  assign lif.yellow_on = s.yellow;

  a_idle_yellow_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (lif.usb_state == UBS_USB_ABSENT) |=> !lif.yellow_on)
    else $error("yellow lit while usb absent");
endmodule
`default_nettype wire

// file: src/ubs_boot_selector.sv
// startup boot decision, image write routing, read-only data and indicator pins
`timescale 1ns/1ps
`default_nettype none
module ubs_boot_selector
  import ubs_pkg::*;
#(
  parameter int unsigned          MS_CYCLES = UBS_MS_CYCLES,
  parameter logic [18*8-1:0]      DEV_DESC  = {128'h0, 16'h0112}, // arbitrary value
  parameter logic [8*8-1:0]       SERIAL    = "00000000" // arbitrary value
)(
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  input  wire logic               boot_select_yellow_pin_in,
  output logic                    boot_select_yellow_pin_out,
  output logic                    boot_select_yellow_pin_oe,
  output logic                    green_indicator_pin_out,
  output logic                    green_indicator_pin_oe,
  input  wire ubs_pkg::ubs_usb_t  usb_link_state,
  input  wire logic               usb_cmd_seen,
  output logic                    ram_clr_we,
  output logic [9:0]              ram_clr_addr,
  output logic                    flash_rd_req,
  output logic [23:0]             flash_rd_addr,
  input  wire logic [15:0]        flash_rd_data,
  input  wire logic               flash_rd_valid,
  input  wire logic               loader_jump,
  input  wire logic [23:0]        cpu_vec_addr,
  output logic [23:0]             cpu_vec_target,
  input  wire logic               img_wr_valid,
  input  wire logic [23:0]        img_wr_addr,
  input  wire logic [7:0]         img_wr_data,
  output logic                    prog_flash_we,
  output logic                    eeprom_we,
  output logic [23:0]             prog_addr,
  output logic [7:0]              prog_data,
  output logic                    img_wr_reject,
  input  wire logic [7:0]         ro_rd_addr,
  output logic [7:0]              ro_rd_data,
  output logic                    loader_mode,
  output logic                    app_run
);
  typedef struct packed {
    ubs_state_t  st;
    logic [9:0]  ram_addr;
    logic        ram_we;
    logic        rd_req;
    logic        pin_s1;
    logic        pin_s2;
    logic        loader;
    logic        app;
    logic [23:0] vec;
    logic        fw;
    logic        ew;
    logic        rej;
    logic [23:0] paddr;
    logic [7:0]  pdata;
    logic [7:0]  ro;
    logic        y_oe;
    logic        g_oe;
  } ubs_top_state_t;

  ubs_top_state_t s;
  ubs_top_state_t next_s;
  logic [1:0]     rst_sync;
  logic           rst_n;
  ubs_led_if      lif ();

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // byte of the read-only area; everything unlisted reads zero
  function automatic logic [7:0] ro_byte(input logic [7:0] a);
    int i;
    ro_byte = 8'h00;
    i = 0;
    if (a >= UBS_DESC_FIRST && a <= UBS_DESC_LAST)
    begin
      i = int'(a - UBS_DESC_FIRST);
      ro_byte = DEV_DESC[8*i +: 8];
    end
    else if (a >= UBS_SER_FIRST && a <= UBS_SER_LAST)
    begin
      i = int'(a - UBS_SER_FIRST);
      if (i < UBS_SERIAL_LEN)
        ro_byte = SERIAL[8*(UBS_SERIAL_LEN-1-i) +: 8];
    end
    else if (a >= UBS_SDESC_FIRST && a <= UBS_SDESC_LAST)
    begin
      i = int'(a - UBS_SDESC_FIRST);
      if (i == 0)
        ro_byte = 8'(2 + 2 * UBS_SERIAL_LEN);
      else if (i == 1)
        ro_byte = UBS_STRING_TYPE;
      else if (i < 2 + 2 * UBS_SERIAL_LEN && i[0] == 1'b0)
        ro_byte = SERIAL[8*(UBS_SERIAL_LEN-1-(i-2)/2) +: 8];
    end
  endfunction

  always_comb
  begin
    next_s        = s;
    next_s.pin_s1 = boot_select_yellow_pin_in;
    next_s.pin_s2 = s.pin_s1;
    next_s.ram_we = 1'b0;
    next_s.rd_req = 1'b0;
    next_s.fw     = 1'b0;
    next_s.ew     = 1'b0;
    next_s.rej    = 1'b0;
    unique case (s.st)
      UBS_ST_CLEAR:
      begin
        next_s.ram_we = 1'b1;
        if (s.ram_we)
          next_s.ram_addr = s.ram_addr + 10'h001;
        if (s.ram_we && s.ram_addr == UBS_RAM_LAST)
        begin
          next_s.ram_we = 1'b0;
          next_s.st     = UBS_ST_READ;
        end
      end
      UBS_ST_READ:
      begin
        next_s.rd_req = 1'b1;
        next_s.st     = UBS_ST_WAIT;
      end
      UBS_ST_WAIT:
      begin
        if (flash_rd_valid)
        begin
          if (flash_rd_data == UBS_BLANK_WORD)
          begin
            next_s.st     = UBS_ST_LOADER;
            next_s.loader = 1'b1;
          end
          else
            next_s.st = UBS_ST_PIN;
        end
      end
      UBS_ST_PIN:
      begin
        // the pin is still undriven here, so the strap level is seen
        if (s.pin_s2)
        begin
          next_s.st     = UBS_ST_LOADER;
          next_s.loader = 1'b1;
        end
        else
        begin
          next_s.st  = UBS_ST_APP;
          next_s.app = 1'b1;
        end
      end
      UBS_ST_LOADER:
      begin
        if (img_wr_valid)
        begin
          next_s.paddr = img_wr_addr;
          next_s.pdata = img_wr_data;
          if (img_wr_addr >= UBS_EE_BASE)
          begin
            next_s.ew    = 1'b1;
            next_s.paddr = img_wr_addr - UBS_EE_BASE;
          end
          else if (img_wr_addr >= UBS_APP_BASE && img_wr_addr < UBS_FLASH_END)
            next_s.fw = 1'b1;
          else
            next_s.rej = 1'b1;
        end
      end
      UBS_ST_APP:
      begin
        // no reset here: the application must have undone clock changes
        if (loader_jump)
        begin
          next_s.st     = UBS_ST_LOADER;
          next_s.loader = 1'b1;
          next_s.app    = 1'b0;
        end
      end
      default:
      begin
        next_s.st = UBS_ST_CLEAR;
      end
    endcase
    unique case (cpu_vec_addr)
      UBS_VEC_HIGH:   next_s.vec = UBS_APP_HIGH;
      UBS_VEC_LOW:    next_s.vec = UBS_APP_LOW;
      UBS_VEC_RESET:  next_s.vec = UBS_VEC_RESET;
      UBS_VEC_LOADER: next_s.vec = UBS_VEC_LOADER;
      default:        next_s.vec = cpu_vec_addr;
    endcase
    if (s.app && cpu_vec_addr == UBS_VEC_RESET)
      next_s.vec = UBS_APP_BASE;
    next_s.ro   = ro_byte(ro_rd_addr);
    next_s.y_oe = lif.yellow_on;
    next_s.g_oe = lif.green_on;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign lif.usb_state = usb_link_state;
  assign lif.cmd_seen  = usb_cmd_seen;
  assign lif.loader_on = s.loader;

  ubs_led_gen #(
    .MS_CYCLES (MS_CYCLES)
  ) u_led (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .lif     (lif)
  );

  // pins only ever driven high; red and vbus sense have no port at all
  assign boot_select_yellow_pin_out = 1'b1;
  assign green_indicator_pin_out    = 1'b1;
  assign boot_select_yellow_pin_oe  = s.y_oe;
  assign green_indicator_pin_oe     = s.g_oe;
  assign ram_clr_we                 = s.ram_we;
  assign ram_clr_addr               = s.ram_addr;
  assign flash_rd_req               = s.rd_req;
  assign flash_rd_addr              = UBS_APP_BASE;
  assign cpu_vec_target             = s.vec;
  assign prog_flash_we              = s.fw;
  assign eeprom_we                  = s.ew;
  assign prog_addr                  = s.paddr;
  assign prog_data                  = s.pdata;
  assign img_wr_reject              = s.rej;
  assign ro_rd_data                 = s.ro;
  assign loader_mode                = s.loader;
  assign app_run                    = s.app;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_blank_seen;
    s.st == UBS_ST_WAIT && flash_rd_valid && flash_rd_data == UBS_BLANK_WORD;
  endsequence
  sequence s_pin_check;
    s.st == UBS_ST_PIN;
  endsequence

  a_pins_high_only: assert property (boot_select_yellow_pin_out && green_indicator_pin_out)
    else $error("indicator pin driven low");
  a_clear_before_read: assert property (ram_clr_we |-> !flash_rd_req && !app_run && !loader_mode)
    else $error("boot decision during ram clear");
  a_blank_loader: assert property (s_blank_seen |=> loader_mode && !app_run)
    else $error("blank application not caught");
  a_pin_loader: assert property (s_pin_check ##0 s.pin_s2 |=> loader_mode && !app_run)
    else $error("boot pin high not honoured");
  a_app_entry: assert property ($rose(app_run) |-> $past(s.st == UBS_ST_PIN) && !$past(s.pin_s2))
    else $error("application started outside startup");
  a_vec_high: assert property (cpu_vec_addr == UBS_VEC_HIGH |=> cpu_vec_target == UBS_APP_HIGH)
    else $error("high vector not forwarded");
  a_vec_low: assert property (cpu_vec_addr == UBS_VEC_LOW |=> cpu_vec_target == UBS_APP_LOW)
    else $error("low vector not forwarded");
  a_jump_loader: assert property (app_run && loader_jump |=> loader_mode && !app_run)
    else $error("loader launch ignored");
  a_flash_guard: assert property (prog_flash_we |-> prog_addr >= UBS_APP_BASE && !eeprom_we)
    else $error("write into loader region");
  a_eeprom_map: assert property (loader_mode && img_wr_valid
    && img_wr_addr >= UBS_EE_BASE
    |=> eeprom_we && prog_addr == $past(img_wr_addr) - UBS_EE_BASE)
    else $error("eeprom mapping wrong");
  a_config_lock: assert property (loader_mode && img_wr_valid
    && img_wr_addr >= UBS_CFG_BASE && img_wr_addr < UBS_EE_BASE
    |=> img_wr_reject && !prog_flash_we && !eeprom_we)
    else $error("configuration write not refused");
  a_serial_tail: assert property (ro_rd_addr == UBS_SER_LAST |=> ro_rd_data == 8'h00)
    else $error("serial tail not zero");
  a_string_type: assert property (ro_rd_addr == UBS_SDESC_FIRST + 8'h01
    |=> ro_rd_data == UBS_STRING_TYPE)
    else $error("string descriptor type wrong");
endmodule
`default_nettype wire

// file: verification/ubs_flash_model.sv
// flash stand-in that answers the startup read of the first application word
`timescale 1ns/1ps
`default_nettype none
module ubs_flash_model (
  input  wire logic        sys_clk,
  input  wire logic        flash_rd_req,
  input  wire logic [23:0] flash_rd_addr,
  input  wire logic [15:0] app_word,
  input  wire logic [7:0]  latency,
  output logic [15:0]      flash_rd_data,
  output logic             flash_rd_valid
);
  logic [15:0] dat  = 16'h0;
  logic        vld  = 1'b0;
  logic        busy = 1'b0;
  logic [7:0]  cnt  = 8'h0;
  assign flash_rd_data  = dat;
  assign flash_rd_valid = vld;
  always @(posedge sys_clk)
  begin
    vld <= 1'b0;
    // data is not held outside the answer cycle
    dat <= ~dat;
    if (flash_rd_req && !busy)
    begin
      busy <= 1'b1;
      cnt  <= latency;
    end
    else if (busy && cnt != 8'h0)
      cnt <= cnt - 8'h1;
    else if (busy)
    begin
      busy <= 1'b0;
      vld  <= 1'b1;
      // entry word sits at the start of the application region
      dat  <= (flash_rd_addr == 24'h002000) ? app_word : ~app_word;
    end
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench: startup decision, image routing, vectors, data area, indicators
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ubs_pkg::*;
  // ms shortened so a blink period is a few thousand cycles
  localparam int unsigned     MSC  = 4;
  localparam logic [8*8-1:0]  SER  = "31415926";
  localparam logic [18*8-1:0] DESC = {64'h0123456789abcdef, 64'h1122334455667788, 16'h0112};
  logic        sys_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        strap   = 1'b0;
  logic        cmd     = 1'b0;
  logic        jump    = 1'b0;
  logic        wv      = 1'b0;
  ubs_usb_t    usb_st  = UBS_USB_ABSENT;
  logic [23:0] va      = 24'h0;
  logic [23:0] wa      = 24'h0;
  logic [7:0]  wd      = 8'h0;
  logic [7:0]  ra      = 8'h0;
  logic [7:0]  lat     = 8'h0;
  logic [15:0] app_word = 16'hffff;
  logic        pin_in, y_out, y_oe, g_out, g_oe, clr_we, rd_req, rd_vld;
  logic        pf_we, ee_we, rej, lmode, arun;
  logic [9:0]  clr_addr;
  logic [23:0] rd_addr, vt, pa;
  logic [15:0] rd_data;
  logic [7:0]  pd, rdat;
  int          miscompares = 0;
  int          tests_run   = 0;

  // strap seen on the shared pin unless the yellow driver owns it
  assign pin_in = y_oe ? y_out : strap;
  always #20 sys_clk = ~sys_clk;

  ubs_boot_selector #(.MS_CYCLES(MSC), .DEV_DESC(DESC), .SERIAL(SER)) DUT (
    .sys_clk(sys_clk), .arst_n(arst_n),
    .boot_select_yellow_pin_in(pin_in), .boot_select_yellow_pin_out(y_out),
    .boot_select_yellow_pin_oe(y_oe), .green_indicator_pin_out(g_out),
    .green_indicator_pin_oe(g_oe), .usb_link_state(usb_st), .usb_cmd_seen(cmd),
    .ram_clr_we(clr_we), .ram_clr_addr(clr_addr), .flash_rd_req(rd_req),
    .flash_rd_addr(rd_addr), .flash_rd_data(rd_data), .flash_rd_valid(rd_vld),
    .loader_jump(jump), .cpu_vec_addr(va), .cpu_vec_target(vt),
    .img_wr_valid(wv), .img_wr_addr(wa), .img_wr_data(wd),
    .prog_flash_we(pf_we), .eeprom_we(ee_we), .prog_addr(pa), .prog_data(pd),
    .img_wr_reject(rej), .ro_rd_addr(ra), .ro_rd_data(rdat),
    .loader_mode(lmode), .app_run(arun));

  ubs_flash_model FLASH (
    .sys_clk(sys_clk), .flash_rd_req(rd_req), .flash_rd_addr(rd_addr),
    .app_word(app_word), .latency(lat), .flash_rd_data(rd_data),
    .flash_rd_valid(rd_vld));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic fail(string m);
    miscompares++;
    $display("ERROR %0t %s", $time, m);
  endtask

  task automatic chk(logic [23:0] got, logic [23:0] exp, string m);
    tests_run++;
    if (got !== exp)
      fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask

  task automatic chk_rng(int got, int lo, int hi, string m);
    tests_run++;
    if (got < lo || got > hi)
      fail($sformatf("%s count %0d", m, got));
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [1:0] route(logic [23:0] a);
    if (a < UBS_APP_BASE || (a >= UBS_FLASH_END && a < UBS_EE_BASE))
      return 2'd2;
    return (a >= UBS_EE_BASE) ? 2'd1 : 2'd0;
  endfunction

  function automatic logic [23:0] pick();
    case ($urandom_range(0, 3))
      0: return 24'($urandom_range(0, 24'h1fff));
      1: return 24'($urandom_range(24'h2000, 24'h7fff));
      2: return 24'($urandom_range(24'h8000, 24'hefffff));
      default: return 24'($urandom_range(24'hf00000, 24'hf000ff));
    endcase
  endfunction

  function automatic logic [23:0] vmap(logic [23:0] a, logic run);
    if (a == UBS_VEC_HIGH)
      return UBS_APP_HIGH;
    if (a == UBS_VEC_LOW)
      return UBS_APP_LOW;
    if (a == UBS_VEC_RESET)
      return run ? UBS_APP_BASE : 24'h0;
    return a;
  endfunction

  function automatic logic [7:0] ro_exp(int a);
    int k;
    if (a <= UBS_DESC_LAST)
      return DESC[8*(a-UBS_DESC_FIRST) +: 8];
    k = (a <= UBS_SER_LAST) ? a - UBS_SER_FIRST : a - UBS_SDESC_FIRST;
    if (a <= UBS_SER_LAST)
      return (k < 8) ? SER[8*(7-k) +: 8] : 8'h0;
    if (k < 2)
      return (k == 0) ? 8'd18 : UBS_STRING_TYPE;
    return (k < 18 && k % 2 == 0) ? SER[8*(7-(k-2)/2) +: 8] : 8'h0;
  endfunction

  task automatic boot(logic [15:0] w, logic s, logic [7:0] l, logic [1:0] mode);
    int n;
    int k;
    int rd;
    app_word = w;
    strap = s;
    lat = l;
    arst_n = 1'b0;
    tick(5);
    arst_n = 1'b1;
    n = 0;
    k = 0;
    rd = 0;
    while (lmode !== 1'b1 && arun !== 1'b1 && n < 3000)
    begin
      if (rd_req === 1'b1)
      begin
        rd++;
        chk(24'(k), 24'd1024, "read before ram clear");
        chk(rd_addr, UBS_APP_BASE, "first word address");
      end
      if (clr_we === 1'b1)
      begin
        chk({14'h0, clr_addr}, 24'(k), "ram clear address");
        k++;
      end
      tick();
      n++;
    end
    if (n == 3000)
    begin
      fail("startup timeout");
      print_verdict();
    end
    chk(24'(rd), 24'd1, "decision without read");
    chk({22'h0, lmode, arun}, {22'h0, mode}, "boot mode");
  endtask

  task automatic writes(logic acc);
    logic [23:0] cor[8];
    logic [1:0]  r;
    cor = '{24'h001fff, 24'h002000, 24'h007fff, 24'h008000,
            UBS_CFG_BASE, 24'hefffff, UBS_EE_BASE, 24'hf000ff};
    for (int i = 0; i < 40; i++)
    begin
      wv = 1'b1;
      wd = 8'($urandom);
      wa = (i < 8) ? cor[i] : pick();
      tick();
      r = route(wa);
      chk({pf_we, ee_we, rej}, acc ? {r == 2'd0, r == 2'd1, r == 2'd2} : 3'b0, "route");
      if (acc && r != 2'd2)
      begin
        chk(pa, (r == 2'd1) ? wa - UBS_EE_BASE : wa, "prog addr");
        chk({16'h0, pd}, {16'h0, wd}, "prog data");
      end
    end
    wv = 1'b0;
  endtask

  task automatic vec(logic run);
    for (int i = 0; i < 12; i++)
    begin
      va = (i == 0) ? UBS_VEC_RESET : (i == 1) ? UBS_VEC_HIGH :
           (i == 2) ? UBS_VEC_LOW : (i == 3) ? UBS_VEC_LOADER : 24'($urandom);
      tick();
      chk(vt, vmap(va, run), "vector target");
    end
  endtask

  task automatic led(ubs_usb_t s, int win, int lo, int hi, int ed, logic yon);
    int g;
    int y;
    int e;
    logic p;
    usb_st = s;
    tick(100);
    g = 0;
    y = 0;
    e = 0;
    p = g_oe;
    repeat (win)
    begin
      g += (g_oe === 1'b1);
      y += (y_oe === 1'b1);
      e += (g_oe === 1'b1 && p === 1'b0);
      p = g_oe;
      if (g_out !== 1'b1 || y_out !== 1'b1)
        fail("indicator pin driven low");
      tick();
    end
    chk_rng(g, lo, hi, "green on time");
    chk_rng(e, ed - 1, ed, "green blinks");
    chk_rng(y, yon ? win : 0, yon ? win : 0, "yellow on time");
  endtask

  initial
  begin
    void'($urandom(30304));
    boot(UBS_BLANK_WORD, 1'b0, 8'd0, 2'b10);
    writes(1'b1);
    vec(1'b0);
    for (int a = 8'h40; a <= 8'ha1; a++)
    begin
      ra = 8'(a);
      tick();
      if (a <= 8'h51 || (a >= 8'h60 && a <= 8'h70) || a >= 8'h80)
        chk({16'h0, rdat}, {16'h0, ro_exp(a)}, "read-only byte");
    end
    led(UBS_USB_ABSENT, 4000, 300, 500, 1, 1'b0);
    led(UBS_USB_ATTACHED, 5600, 2700, 2900, 1, 1'b1);
    cmd = 1'b1;
    tick();
    cmd = 1'b0;
    tick(5);
    chk({23'h0, y_oe}, 24'h0, "yellow flash off");
    tick(300);
    chk({23'h0, y_oe}, 24'h1, "yellow back on");
    led(UBS_USB_CONFIGURED, 5600, 700, 900, 2, 1'b1);
    led(UBS_USB_SUSPEND, 4000, 300, 500, 1, 1'b0);
    boot(16'($urandom_range(0, 16'hfffe)), 1'b1, 8'd9, 2'b10);
    boot(16'($urandom_range(0, 16'hfffe)), 1'b0, 8'($urandom_range(0, 20)), 2'b01);
    chk({22'h0, g_oe, y_oe}, 24'h0, "indicators off in application");
    writes(1'b0);
    vec(1'b1);
    // application drops usb and lets the host see the disconnect first
    usb_st = UBS_USB_ABSENT;
    tick(100 * MSC);
    jump = 1'b1;
    tick();
    jump = 1'b0;
    chk({22'h0, lmode, arun}, 24'h2, "loader jump");
    print_verdict();
  end
endmodule
`default_nettype wire
